// file: hw/plr_link_ctrl.sv
// Link-side request serialiser and line state owner for the phy interface.
`timescale 1ns/1ps
module plr_link_ctrl
  import plr_pkg::*;
#(
  parameter int DataW = DATA_W_200
)
(
  input  wire logic       core_clk,
  input  wire logic       srst,
  // Line state pins, three-signal form
  input  wire logic [1:0] lineStateIn,
  output logic [1:0]      lineStateOut,
  output logic            lineStateOe,
  output logic            linkRequestLine,
  // Request port
  input  wire logic       reqValid,
  output logic            reqReady,
  input  wire logic [2:0] reqKind,
  input  wire logic [1:0] reqSpeed,
  input  wire logic [3:0] reqAddr,
  input  wire logic [7:0] reqData,
  output logic            reqSent,
  output logic            reqLost,
  output logic            reqRejected,
  output logic            reqGranted,
  // Transmit control, valid while the link owns the lines
  input  wire logic       txSend,
  input  wire logic       txDone,
  input  wire logic       txChain,
  output logic            linkOwnsBus,
  // Decoded phy line state
  output logic            phyIdle,
  output logic            phyStatus,
  output logic            phyReceive,
  output logic            phyGrant
);

  // ==================================================================
  // Parameter check
  if (DataW != DATA_W_100 && DataW != DATA_W_200) begin : g_bad_data_w
    $error("plr_link_ctrl: DataW must be 2 or 4");
  end
  // A write stream must fit in the frame buffer
  if (FRAME_W < int'(LEN_WRITE)) begin : g_bad_frame_w
    $error("plr_link_ctrl: frame too narrow for a write request");
  end

  // ==================================================================
  // Types and state
  typedef enum logic [2:0] {
    RQ_IDLE,
    RQ_WAIT_IDLE,
    RQ_LOAD,
    RQ_SEND,
    RQ_PENDING
  } plr_rq_e;

  typedef enum logic [1:0] {
    BUS_PHY,
    BUS_HOLD,
    BUS_XMIT,
    BUS_RELEASE
  } plr_bus_e;

  plr_rq_e             rqState_q;
  plr_bus_e            busState_q;
  logic [2:0]          kind_q;
  logic [1:0]          speed_q;
  logic [3:0]          addr_q;
  logic [7:0]          data_q;
  logic                lost_q;
  logic                shiftLoad;
  logic                shiftBusy;
  logic                stopSent;
  logic [FRAME_W-1:0]  frame;
  logic [4:0]          frameLen;
  logic                legalReq;
  logic                takeReq;
  logic                lostNow;
  logic                streamDone;

  // ==================================================================
  // Helpers
  function automatic logic isBusKind(input logic [2:0] kind);
    isBusKind = kind == KIND_IMMEDIATE || kind == KIND_ISO
             || kind == KIND_PRIORITY  || kind == KIND_FAIR;
  endfunction

  // Only fair and priority must wait for idle and can be lost
  function automatic logic isArbKind(input logic [2:0] kind);
    isArbKind = kind == KIND_PRIORITY || kind == KIND_FAIR;
  endfunction

  // Reserved kinds, and the reserved speed on a bus request, are never sent
  function automatic logic isLegalReq(input logic [2:0] kind, input logic [1:0] speed);
    isLegalReq = kind <= KIND_REG_WRITE
              && !(isBusKind(kind) && speed == SPEED_RSVD);
  endfunction

  function automatic logic [FRAME_W-1:0] buildFrame(
    input logic [2:0] kind,
    input logic [1:0] speed,
    input logic [3:0] addr,
    input logic [7:0] data
  );
    logic [FRAME_W-1:0] f;
    f = '0;
    f[POS_START] = START_BIT;
    f[POS_KIND +: 3] = kind;
    if (isBusKind(kind)) begin
      f[POS_SPEED +: 2] = speed;
      f[LEN_BUS - 5'h01] = STOP_BIT;
    end else begin
      f[POS_ADDR +: 4] = addr;
      if (kind == KIND_REG_WRITE) begin
        f[POS_DATA +: 8] = data;
      end
    end
    buildFrame = f;
  endfunction

  function automatic logic [4:0] frameLength(input logic [2:0] kind);
    if (isBusKind(kind)) begin
      frameLength = LEN_BUS;
    end else if (kind == KIND_REG_READ) begin
      frameLength = LEN_READ;
    end else begin
      frameLength = LEN_WRITE;
    end
  endfunction

  // ==================================================================
  // Line decode
  plr_line_decoder u_decoder (
    .core_clk    (core_clk),
    .srst        (srst),
    .lineStateIn (lineStateIn),
    .linkOwns    (lineStateOe),
    .phyIdle     (phyIdle),
    .phyStatus   (phyStatus),
    .phyReceive  (phyReceive),
    .phyGrant    (phyGrant)
  );

  // ==================================================================
  // Request intake
  assign reqReady = rqState_q == RQ_IDLE;
  assign takeReq  = reqValid && reqReady;

  assign legalReq = isLegalReq(reqKind, reqSpeed);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      kind_q  <= KIND_IMMEDIATE;
      speed_q <= SPEED_100;
      addr_q  <= 4'h0;
      data_q  <= 8'h00;
    end else if (takeReq && legalReq) begin
      kind_q  <= reqKind;
      speed_q <= reqSpeed;
      addr_q  <= reqAddr;
      data_q  <= reqData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reqRejected <= 1'b0;
    end else begin
      reqRejected <= takeReq && !legalReq;
    end
  end

  // ==================================================================
  // Request sequencing
  assign frame     = buildFrame(kind_q, speed_q, addr_q, data_q);
  assign frameLen  = frameLength(kind_q);
  assign shiftLoad = rqState_q == RQ_LOAD;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rqState_q <= RQ_IDLE;
    end else begin
      case (rqState_q)
        RQ_IDLE: begin
          if (takeReq && legalReq) begin
            rqState_q <= isArbKind(reqKind) ? RQ_WAIT_IDLE : RQ_LOAD;
          end
        end
        RQ_WAIT_IDLE: begin
          // Decoded idle is one clock late, giving the required clock
          if (phyIdle) begin
            rqState_q <= RQ_LOAD;
          end
        end
        RQ_LOAD: begin
          if (!shiftBusy) begin
            rqState_q <= RQ_SEND;
          end
        end
        RQ_SEND: begin
          if (stopSent) begin
            if (!isBusKind(kind_q)) begin
              rqState_q <= RQ_IDLE;
            end else if (lost_q || (isArbKind(kind_q) && phyReceive)) begin
              rqState_q <= RQ_WAIT_IDLE;
            end else begin
              rqState_q <= RQ_PENDING;
            end
          end
        end
        RQ_PENDING: begin
          // Immediate waits through reception; grant follows the next idle
          if (phyGrant) begin
            rqState_q <= RQ_IDLE;
          end else if (isArbKind(kind_q) && phyReceive) begin
            rqState_q <= RQ_WAIT_IDLE;
          end
        end
        default: rqState_q <= RQ_IDLE;
      endcase
    end
  end

  // Receive seen while the stream is still going out
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lost_q <= 1'b0;
    end else if (rqState_q == RQ_LOAD) begin
      lost_q <= 1'b0;
    end else if (rqState_q == RQ_SEND && isArbKind(kind_q) && phyReceive) begin
      lost_q <= 1'b1;
    end
  end

  // ==================================================================
  // Status pulses
  assign streamDone = rqState_q == RQ_SEND && stopSent;
  // Loss is reported once, at the first receive seen while the request is out
  assign lostNow    = isArbKind(kind_q) && phyReceive
                   && ((rqState_q == RQ_SEND && !lost_q)
                       || (rqState_q == RQ_PENDING && !phyGrant));

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reqSent <= 1'b0;
    end else begin
      reqSent <= streamDone;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reqLost <= 1'b0;
    end else begin
      reqLost <= lostNow;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reqGranted <= 1'b0;
    end else begin
      reqGranted <= rqState_q == RQ_PENDING && phyGrant;
    end
  end

  plr_req_shifter u_shifter (
    .core_clk        (core_clk),
    .srst            (srst),
    .load            (shiftLoad),
    .frame           (frame),
    .frameLen        (frameLen),
    .busy            (shiftBusy),
    .stopSent        (stopSent),
    .linkRequestLine (linkRequestLine)
  );

  // ==================================================================
  // Line ownership
  always_ff @(posedge core_clk) begin
    if (srst) begin
      busState_q <= BUS_PHY;
    end else begin
      case (busState_q)
        BUS_PHY: begin
          // Taken from the registered decode, one clock after the pins show it
          if (phyGrant) begin
            busState_q <= BUS_HOLD;
          end
        end
        BUS_HOLD: begin
          if (txSend) begin
            busState_q <= BUS_XMIT;
          end
        end
        BUS_XMIT: begin
          if (txDone) begin
            // Chaining keeps the bus with no new arbitration
            busState_q <= txChain ? BUS_HOLD : BUS_RELEASE;
          end
        end
        BUS_RELEASE: begin
          busState_q <= BUS_PHY;
        end
        default: busState_q <= BUS_PHY;
      endcase
    end
  end

  // Output flops follow the state a cycle later; code 11 is never produced
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lineStateOut <= LNK_IDLE;
    end else begin
      case (busState_q)
        BUS_HOLD: begin
          lineStateOut <= LNK_HOLD;
        end
        BUS_XMIT: begin
          lineStateOut <= LNK_XMIT;
        end
        BUS_RELEASE: begin
          lineStateOut <= LNK_IDLE;
        end
        default: begin
          lineStateOut <= LNK_IDLE;
        end
      endcase
    end
  end

  // Drivers stay off unless a grant has been taken
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lineStateOe <= 1'b0;
    end else begin
      lineStateOe <= busState_q != BUS_PHY;
    end
  end

  assign linkOwnsBus = lineStateOe;

endmodule // plr_link_ctrl

// file: hw/plr_pkg.sv
// Constants shared by the link request and line state logic.
// ====================================================================
// Behaviour
// - Phy-driven line code 00 is idle, the default state.
// - Phy-driven line code 01 marks status information arriving.
// - Phy-driven line code 10 marks an incoming packet.
// - Phy-driven line code 11 grants the bus to the link.
// - Link drives the line pins only after a grant, otherwise leaves them.
// - Link drives 00 after transmission to release the bus.
// - Link drives 01 to hold while preparing or to chain another packet.
// - Link drives 10 while sending an outgoing packet.
// - Link sends a serial request stream for bus or register access.
// - Every stream starts with bit 1 and ends with stop bit 0.
// - Bus request: 7 bits, start, kind 1-3, speed 4-5, stop.
// - Read request: 9 bits, start, kind 1-3, address 4-7, stop.
// - Write request: 17 bits, start, kind, address, data 8-15, stop.
// - Kind 000 is immediate, granted without arbitration on next idle.
// - Kind 001 is isochronous, arbitrating after an isochronous gap.
// - Kind 010 is priority, fair gap, no fairness protocol.
// - Kind 011 is fair, fair gap, obeys fairness protocol.
// - Kind 100 reads a phy register, answered by a status transfer.
// - Kind 101 writes the data byte into the addressed phy register.
// - Speed field: 00 100, 01 200, 10 400 Mbit/s, 11 reserved.
// - Fair or priority request issued at least one clock after idle.
// - Receive code during or after request means lost; reissue after idle. The code applies this to fair and priority requests only.
// - Data bus is 2 bits at 100 and 4 bits at 200 Mbit/s.
package plr_pkg;

  // ==================================================================
  // Line codes while the phy owns the lines
  localparam logic [1:0] PHY_IDLE    = 2'h0;
  localparam logic [1:0] PHY_STATUS  = 2'h1;
  localparam logic [1:0] PHY_RECEIVE = 2'h2;
  localparam logic [1:0] PHY_GRANT   = 2'h3;

  // ==================================================================
  // Line codes while the link owns the lines
  localparam logic [1:0] LNK_IDLE    = 2'h0;
  localparam logic [1:0] LNK_HOLD    = 2'h1;
  localparam logic [1:0] LNK_XMIT    = 2'h2;

  // ==================================================================
  // Request kinds and speeds
  localparam logic [2:0] KIND_IMMEDIATE = 3'h0;
  localparam logic [2:0] KIND_ISO       = 3'h1;
  localparam logic [2:0] KIND_PRIORITY  = 3'h2;
  localparam logic [2:0] KIND_FAIR      = 3'h3;
  localparam logic [2:0] KIND_REG_READ  = 3'h4;
  localparam logic [2:0] KIND_REG_WRITE = 3'h5;
  localparam logic [1:0] SPEED_100      = 2'h0;
  localparam logic [1:0] SPEED_200      = 2'h1;
  localparam logic [1:0] SPEED_400      = 2'h2;
  localparam logic [1:0] SPEED_RSVD     = 2'h3;

  // ==================================================================
  // Stream layout
  localparam int          FRAME_W       = 17;
  localparam logic [4:0]  LEN_BUS       = 5'h07;
  localparam logic [4:0]  LEN_READ      = 5'h09;
  localparam logic [4:0]  LEN_WRITE     = 5'h11;
  localparam int          POS_START     = 0;
  localparam int          POS_KIND      = 1;
  localparam int          POS_SPEED     = 4;
  localparam int          POS_ADDR      = 4;
  localparam int          POS_DATA      = 8;
  localparam logic        START_BIT     = 1'b1;
  localparam logic        STOP_BIT      = 1'b0;
  localparam int          DATA_W_100    = 2;
  localparam int          DATA_W_200    = 4;

endpackage

// file: hw/plr_line_decoder.sv
// Registered decode of the phy-driven line state pins.
`timescale 1ns/1ps
module plr_line_decoder
  import plr_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic [1:0] lineStateIn,
  input  wire logic       linkOwns,
  output logic            phyIdle,
  output logic            phyStatus,
  output logic            phyReceive,
  output logic            phyGrant
);
  // Decode is blanked while the link drives the pins itself
  always_ff @(posedge core_clk) begin
    if (srst) begin
      phyIdle    <= 1'b1;
      phyStatus  <= 1'b0;
      phyReceive <= 1'b0;
      phyGrant   <= 1'b0;
    end else begin
      phyIdle    <= !linkOwns && lineStateIn == PHY_IDLE;
      phyStatus  <= !linkOwns && lineStateIn == PHY_STATUS;
      phyReceive <= !linkOwns && lineStateIn == PHY_RECEIVE;
      phyGrant   <= !linkOwns && lineStateIn == PHY_GRANT;
    end
  end

endmodule // plr_line_decoder

// file: hw/plr_req_shifter.sv
// Serial shifter for request streams on the link request line.
`timescale 1ns/1ps
module plr_req_shifter
  import plr_pkg::*;
#(
  parameter int FrameW = FRAME_W
)
(
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              load,
  input  wire logic [FrameW-1:0] frame,
  input  wire logic [4:0]        frameLen,
  output logic                   busy,
  output logic                   stopSent,
  output logic                   linkRequestLine
);
  logic [FrameW-1:0] shift_q;
  logic [4:0]        left_q;

  if (FrameW < FRAME_W) begin : g_bad_frame_w
    $error("plr_req_shifter: FrameW too small");
  end

  assign busy = left_q != 5'h00;

  // Load is ignored while busy, so streams never overlap
  always_ff @(posedge core_clk) begin
    if (srst) begin
      shift_q <= '0;
      left_q  <= 5'h00;
    end else if (load && !busy) begin
      shift_q <= frame;
      left_q  <= frameLen;
    end else if (busy) begin
      shift_q <= {1'b0, shift_q[FrameW-1:1]};
      left_q  <= left_q - 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      linkRequestLine <= 1'b0;
      stopSent        <= 1'b0;
    end else begin
      linkRequestLine <= busy ? shift_q[0] : 1'b0;
      stopSent        <= left_q == 5'h01;
    end
  end

endmodule // plr_req_shifter

// file: tb/plr_link_ctrl_asserts.sv
// Concurrent checks on the link request and line state ports.
`timescale 1ns/1ps
module plr_link_ctrl_chk
  import plr_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic [1:0] lineStateIn,
  input wire logic [1:0] lineStateOut,
  input wire logic       lineStateOe,
  input wire logic       linkRequestLine,
  input wire logic       reqValid,
  input wire logic       reqReady,
  input wire logic [2:0] reqKind,
  input wire logic [1:0] reqSpeed,
  input wire logic       reqSent,
  input wire logic       reqLost,
  input wire logic       reqRejected,
  input wire logic       txSend,
  input wire logic       txDone,
  input wire logic       txChain,
  input wire logic       phyGrant,
  input wire logic       phyStatus,
  input wire logic       phyReceive
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // ==================================================================
  // Sequences
  sequence s_take_reg;
    reqValid && reqReady && reqKind[2:1] == 2'h2;
  endsequence
  sequence s_release;
    lineStateOut == LNK_IDLE ##1 !lineStateOe;
  endsequence
  // ==================================================================
  // Line ownership
  a_no_rsvd_code: assert property (lineStateOe |-> lineStateOut != 2'h3)
    else $error("reserved line code driven");
  a_grant_hold: assert property ((lineStateIn == PHY_GRANT && !lineStateOe && !phyGrant)
    |-> ##3 (lineStateOe && lineStateOut == LNK_HOLD)) else $error("grant not taken");
  a_oe_after_grant: assert property ($rose(lineStateOe) |-> $past(phyGrant))
    else $error("lines driven without grant");
  a_send_xmit: assert property ((lineStateOe && txSend && lineStateOut == LNK_HOLD)
    |-> ##2 lineStateOut == LNK_XMIT) else $error("transmit code missing");
  a_done_release: assert property ((lineStateOe && txDone && !txChain
    && lineStateOut == LNK_XMIT) |-> ##2 s_release) else $error("release wrong");
  a_chain_hold: assert property ((lineStateOe && txDone && txChain
    && lineStateOut == LNK_XMIT) |-> ##2 lineStateOut == LNK_HOLD ##1 lineStateOe)
    else $error("chain hold wrong");
  a_decode_status: assert property ((!lineStateOe && lineStateIn == PHY_STATUS) |=> phyStatus)
    else $error("status not decoded");
  a_decode_rx: assert property ((!lineStateOe && lineStateIn == PHY_RECEIVE) |=> phyReceive)
    else $error("receive not decoded");
  // ==================================================================
  // Request line
  a_reg_stream: assert property (s_take_reg |-> ##3 linkRequestLine
    ##2 !linkRequestLine ##1 linkRequestLine) else $error("register stream head wrong");
  a_reject_rsvd: assert property ((reqValid && reqReady && (reqKind[2:1] == 2'h3
    || (!reqKind[2] && reqSpeed == SPEED_RSVD))) |=> reqRejected ##1 !linkRequestLine)
    else $error("reserved request not dropped");
  a_stop_sent: assert property (reqSent |-> !$past(linkRequestLine))
    else $error("stop bit not low");
  a_idle_low: assert property (reqReady |-> !linkRequestLine)
    else $error("request line busy while idle");
  a_lost_cause: assert property (reqLost |->
    (phyReceive || $past(phyReceive) || $past(phyReceive, 2))) else $error("loss without receive");
endmodule // plr_link_ctrl_chk

bind plr_link_ctrl plr_link_ctrl_chk u_chk (
  .core_clk, .srst, .lineStateIn, .lineStateOut, .lineStateOe, .linkRequestLine,
  .reqValid, .reqReady, .reqKind, .reqSpeed, .reqSent, .reqLost, .reqRejected,
  .txSend, .txDone, .txChain, .phyGrant, .phyStatus, .phyReceive
);

// file: tb/plr_phy_model.sv
// Behavioural phy: drives line codes and captures request streams.
`timescale 1ns/1ps
module plr_phy_model
  import plr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        linkRequestLine,
  input  wire logic [1:0]  phyCode,
  output logic [1:0]       phyLine,
  output logic [16:0]      capBits,
  output logic [4:0]       capLen,
  output int               capCount
);
  logic        busy;
  logic [16:0] vec;
  logic [4:0]  len;
  int          idx;

  // Idle, status, receive or grant as commanded
  assign phyLine = phyCode;

  initial begin
    busy = 1'b0;
    capCount = 0;
    capBits = '0;
    capLen = '0;
  end

  // ==================================================================
  // Stream capture, bit 0 first; length known once the kind is in
  always @(posedge core_clk) begin
    if (!busy) begin
      if (linkRequestLine === START_BIT) begin
        busy = 1'b1;
        vec = 17'h00001;
        idx = 1;
      end
    end else begin
      vec[idx] = linkRequestLine;
      if (idx == 3) begin
        len = (vec[3:1] == KIND_REG_WRITE) ? 5'h11 :
              (vec[3:1] == KIND_REG_READ) ? 5'h09 : 5'h07;
      end
      if (idx >= 3 && idx == int'(len) - 1) begin
        busy = 1'b0;
        capBits = vec;
        capLen = len;
        capCount++;
      end
      idx++;
    end
  end
endmodule // plr_phy_model

// file: tb/tb_plr_link_ctrl.sv
// Self-checking bench for the link request and line state block.
`timescale 1ns/1ps
module tb_plr_link_ctrl;
  import plr_pkg::*;
  logic        core_clk, srst, lineStateOe, linkRequestLine;
  logic [1:0]  phyCode, phyLine, lineStateIn, lineStateOut, reqSpeed;
  logic        reqValid, reqReady, reqSent, reqLost, reqRejected, reqGranted;
  logic [2:0]  reqKind;
  logic [3:0]  reqAddr;
  logic [7:0]  reqData;
  logic        txSend, txDone, txChain, linkOwnsBus;
  logic        phyIdle, phyStatus, phyReceive, phyGrant;
  logic [16:0] capBits;
  logic [4:0]  capLen;
  int          capCount, badCount, cmpCount, nSent, nLost, nRej, nGrant;

  // Phy yields the wire whenever the link enables its drivers
  assign lineStateIn = lineStateOe ? lineStateOut : phyLine;

  plr_link_ctrl uut (.core_clk, .srst, .lineStateIn, .lineStateOut, .lineStateOe,
    .linkRequestLine, .reqValid, .reqReady, .reqKind, .reqSpeed, .reqAddr, .reqData,
    .reqSent, .reqLost, .reqRejected, .reqGranted, .txSend, .txDone, .txChain,
    .linkOwnsBus, .phyIdle, .phyStatus, .phyReceive, .phyGrant);
  plr_phy_model phy (.core_clk, .linkRequestLine, .phyCode, .phyLine, .capBits, .capLen,
    .capCount);

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (reqSent === 1'b1) nSent++;
    if (reqLost === 1'b1) nLost++;
    if (reqRejected === 1'b1) nRej++;
    if (reqGranted === 1'b1) nGrant++;
  end

  // ==================================================================
  // Helpers
  task tick;
    @(posedge core_clk);
    #1;
  endtask
  task chk(input logic [16:0] got, input logic [16:0] exp);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task summarize;
    if (badCount == 0 && cmpCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic issue(input logic [2:0] k, input logic [1:0] s, input logic [3:0] a,
                       input logic [7:0] d);
    while (reqReady !== 1'b1) tick;
    reqValid = 1'b1;
    reqKind = k;
    reqSpeed = s;
    reqAddr = a;
    reqData = d;
    tick;
    reqValid = 1'b0;
    tick;
  endtask
  task automatic send_req(input logic [2:0] k, input logic [1:0] s, input logic [3:0] a,
                          input logic [7:0] d);
    int n;
    logic [16:0] f;
    n = capCount;
    f = 17'h00001;
    f[3:1] = k;
    if (k == KIND_REG_WRITE) f[15:4] = {d, a};
    else if (k == KIND_REG_READ) f[7:4] = a;
    else f[5:4] = s;
    issue(k, s, a, d);
    wait (capCount == n + 1);
    #1;
    chk(capBits, f);
    chk(17'(capLen), (k == KIND_REG_WRITE) ? 17'h11 : (k == KIND_REG_READ) ? 17'h9 : 17'h7);
  endtask
  task automatic send_pkt(input logic chain);
    txSend = 1'b1;
    repeat (3) tick;
    chk(17'(lineStateOut), 17'(LNK_XMIT));
    txSend = 1'b0;
    txDone = 1'b1;
    txChain = chain;
    tick;
    txDone = 1'b0;
    txChain = 1'b0;
    tick;
    chk(17'(lineStateOut), chain ? 17'(LNK_HOLD) : 17'(LNK_IDLE));
    chk(17'(lineStateOe), 17'h1);
    tick;
    chk(17'(lineStateOe), 17'(chain));
    chk(17'(linkOwnsBus), 17'(chain));
  endtask
  task automatic take_bus(input logic chain);
    int g;
    g = nGrant;
    phyCode = PHY_GRANT;
    wait (lineStateOe === 1'b1);
    #1;
    phyCode = PHY_IDLE;
    chk(17'(lineStateOut), 17'(LNK_HOLD));
    if (chain) send_pkt(1'b1);
    send_pkt(1'b0);
    chk(17'(nGrant), 17'(g + 1));
  endtask

  // ==================================================================
  // Scenarios
  task t_reset;
    chk(17'({lineStateOe, linkRequestLine, phyIdle, reqReady}), 17'h3);
  endtask
  task t_decode;
    for (int c = 0; c < 3; c++) begin
      phyCode = 2'(c);
      tick;
      chk(17'({phyIdle, phyStatus, phyReceive, phyGrant}), 17'(4'h8 >> c));
    end
    phyCode = PHY_IDLE;
    tick;
  endtask
  task t_reg;
    int s;
    s = nSent;
    send_req(KIND_REG_READ, SPEED_100, 4'hF, 8'h00);
    send_req(KIND_REG_WRITE, SPEED_100, 4'hA, 8'hA5);
    wait (nSent == s + 2);
    #1;
  endtask
  task t_bus;
    send_req(KIND_IMMEDIATE, SPEED_100, 4'h0, 8'h00);
    take_bus(1'b0);
    send_req(KIND_ISO, SPEED_200, 4'h0, 8'h00);
    take_bus(1'b0);
    send_req(KIND_PRIORITY, SPEED_400, 4'h0, 8'h00);
    take_bus(1'b0);
    send_req(KIND_FAIR, SPEED_200, 4'h0, 8'h00);
    take_bus(1'b1);
  endtask
  task t_reject;
    int n;
    int r;
    n = capCount;
    r = nRej;
    issue(3'h6, SPEED_100, 4'h0, 8'h00);
    issue(3'h7, SPEED_100, 4'h0, 8'h00);
    issue(KIND_PRIORITY, SPEED_RSVD, 4'h0, 8'h00);
    repeat (4) tick;
    chk(17'(nRej), 17'(r + 3));
    chk(17'(capCount), 17'(n));
  endtask
  task t_lost;
    int n;
    int l;
    l = nLost;
    send_req(KIND_FAIR, SPEED_400, 4'h0, 8'h00);
    phyCode = PHY_RECEIVE;
    wait (nLost == l + 1);
    #1;
    n = capCount;
    repeat (5) tick;
    chk(17'(capCount), 17'(n));
    phyCode = PHY_IDLE;
    wait (capCount == n + 1);
    #1;
    chk(capBits, 17'h00027);
    take_bus(1'b0);
  endtask

  initial begin
    core_clk = 1'b0;
    srst = 1'b1;
    phyCode = PHY_IDLE;
    {reqValid, reqKind, reqSpeed, reqAddr, reqData} = '0;
    {txSend, txDone, txChain} = '0;
    repeat (8) @(posedge core_clk);
    #1;
    srst = 1'b0;
    t_reset;
    t_decode;
    t_reg;
    t_bus;
    t_reject;
    t_lost;
    repeat (5) tick;
    summarize;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    badCount++;
    summarize;
  end
endmodule // tb_plr_link_ctrl
